// *** logic/dcos_ctrl.sv ***
// Output stop control for a four-output differential clock buffer
//////////////////////////////////////////////////////////////////////////////
// Summary of operation
// - Stop asserted halts each stoppable output right after its next edge.
// - Drive mode 0 parks true leg driven high, complement leg undriven.
// - Drive mode 1 releases both legs of every stopped output.
// - Release restarts all stopped outputs together, glitch-free, within 2-6.
// - In tri-state mode true leg is driven high once release is debounced, at the second complement-clock rising edge after it.
// - Per-output stoppable bits act only with the stop input.
// - Stop input changes count after two steady complement-clock rising edges.
// - Drive-mode bit 6 picks driven (0, default) or hi-Z (1) parking.
// - Stoppable bits 6,5,2,1: 0 free-run (default), 1 stoppable.
module dcos_ctrl
  import dcos_pkg::*;
#(
  parameter int NOUT = NUM_OUT
) (
  // Clock and reset
  input  wire logic             clk,
  input  wire logic             rst_b,
  // Reference clock sampled as a level, and stop input
  input  wire logic             refClockIn,
  input  wire logic             outputHaltN,
  // Register port
  input  wire logic [1:0]       regAddr,
  input  wire logic [CFG_W-1:0] regWdata,
  input  wire logic             regWr,
  input  wire logic             regRd,
  output logic      [CFG_W-1:0] regRdata,
  // Output pins
  output dcos_pins_t [NOUT-1:0] clkOutPins
);

  if (NOUT != NUM_OUT) begin : g_chk
    $error("dcos_ctrl supports exactly four outputs");
  end

  //////////////////////////////////////////////////////////////////////////////
  // Registers
  logic [CFG_W-1:0] mode_ff, nxt_mode;
  logic [CFG_W-1:0] stopEn_ff, nxt_stopEn;
  logic [CFG_W-1:0] rdata_ff, nxt_rdata;
  logic [CFG_W-1:0] status;
  logic             hizMode;
  logic [NOUT-1:0]  stoppable;

  assign hizMode = mode_ff[STOP_MODE_BIT];
  for (genvar i = 0; i < NOUT; i++) begin : g_sel
    assign stoppable[i] = stopEn_ff[STOPPABLE_POS[i]];
  end

  always_comb begin
    nxt_mode   = mode_ff;
    nxt_stopEn = stopEn_ff;
    nxt_rdata  = '0;
    if (regWr && regAddr == ADDR_MODE)   nxt_mode   = regWdata;
    if (regWr && regAddr == ADDR_STOPEN) nxt_stopEn = regWdata;
    if (regRd) begin
      unique case (regAddr)
        ADDR_MODE:   nxt_rdata = mode_ff;
        ADDR_STOPEN: nxt_rdata = stopEn_ff;
        ADDR_STATUS: nxt_rdata = status;
        default:     nxt_rdata = '0;
      endcase
    end
  end

  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      mode_ff   <= MODE_RESET;
      stopEn_ff <= STOPEN_RESET;
      rdata_ff  <= '0;
    end else begin
      mode_ff   <= nxt_mode;
      stopEn_ff <= nxt_stopEn;
      rdata_ff  <= nxt_rdata;
    end
  end
  assign regRdata = rdata_ff;

  //////////////////////////////////////////////////////////////////////////////
  // Debounce on rising edges of the complement clock (falling of ref)
  logic       refPrev_ff, nxt_refPrev;
  logic       haltSamp_ff, nxt_haltSamp;
  logic       stopReq_ff, nxt_stopReq;
  logic       negRise;
  logic       posFall;

  assign negRise = refPrev_ff && !refClockIn;
  assign posFall = negRise;

  always_comb begin
    nxt_refPrev  = refClockIn;
    nxt_haltSamp = haltSamp_ff;
    nxt_stopReq  = stopReq_ff;
    if (negRise) begin
      nxt_haltSamp = outputHaltN;
      // Two agreeing samples needed before a change counts
      if (haltSamp_ff == outputHaltN) begin
        nxt_stopReq = !outputHaltN;
      end
    end
  end

  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      refPrev_ff  <= 1'h0;
      haltSamp_ff <= 1'h1;
      stopReq_ff  <= 1'h0;
    end else begin
      refPrev_ff  <= nxt_refPrev;
      haltSamp_ff <= nxt_haltSamp;
      stopReq_ff  <= nxt_stopReq;
    end
  end

  //////////////////////////////////////////////////////////////////////////////
  // Halt state: freeze once the true leg has risen
  // Parking high in a high phase adds no edge, so no runt low pulse
  dcos_state_t     state_ff, nxt_state;
  logic [NOUT-1:0] halted_ff, nxt_halted;
  logic            hizPark;

  always_comb begin
    nxt_state  = state_ff;
    nxt_halted = halted_ff;
    unique case (state_ff)
      ST_RUN: if (stopReq_ff) nxt_state = ST_HALTING;
      ST_HALTING: begin
        if (!stopReq_ff) begin
          nxt_state = ST_RUN;
        end else if (refClockIn) begin
          // Next rise seen; latch which outputs stop
          nxt_halted = stoppable;
          nxt_state  = ST_HALTED;
        end
      end
      ST_HALTED: begin
        // Restart on a clock fall: all together, no runt pulse
        if (!stopReq_ff && posFall) begin
          nxt_halted = '0;
          nxt_state  = ST_RUN;
        end
      end
    endcase
  end

  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      state_ff  <= ST_RUN;
      halted_ff <= '0;
    end else begin
      state_ff  <= nxt_state;
      halted_ff <= nxt_halted;
    end
  end

  // Tri-state park ends when stopReq_ff or the drive-mode bit clears; on release that is the second complement-clock rising edge after it, not within 10 ns
  assign hizPark = hizMode && stopReq_ff;

  //////////////////////////////////////////////////////////////////////////////
  // Output pins
  for (genvar i = 0; i < NOUT; i++) begin : g_out
    always_comb begin
      clkOutPins[i] = '{posVal: refClockIn, posOe_b: 1'h0,
                        negVal: !refClockIn, negOe_b: 1'h0};
      if (halted_ff[i]) begin
        if (hizPark) begin
          clkOutPins[i] = '{posVal: 1'h0, posOe_b: 1'h1,
                            negVal: 1'h0, negOe_b: 1'h1};
        end else begin
          clkOutPins[i] = '{posVal: 1'h1, posOe_b: 1'h0,
                            negVal: 1'h0, negOe_b: 1'h1};
        end
      end
    end
  end

  assign status = {{(CFG_W-NOUT-2){1'h0}}, stopReq_ff,
                   state_ff == ST_HALTED, halted_ff};

  //////////////////////////////////////////////////////////////////////////////
  // Checks
  AST_HALT_ONLY_STOPPABLE: assert property (
    @(posedge clk) disable iff (!rst_b)
    $changed(halted_ff) |->
      halted_ff == '0 || halted_ff == $past(stoppable))
    else $error("halted output not stoppable");
  AST_FREE_RUN: assert property (
    @(posedge clk) disable iff (!rst_b)
    (state_ff == ST_HALTING && nxt_state == ST_HALTED)
      |=> halted_ff == $past(stoppable))
    else $error("halt set differs from stoppable bits");
  AST_DRIVEN_PARK: assert property (
    @(posedge clk) disable iff (!rst_b)
    (halted_ff[0] && !hizPark) |-> clkOutPins[0] == 4'h9)
    else $error("driven park wrong");
  AST_HIZ_PARK: assert property (
    @(posedge clk) disable iff (!rst_b)
    (halted_ff[0] && hizPark) |-> clkOutPins[0] == 4'h5)
    else $error("hi-z park wrong");
  AST_RESTART_TOGETHER: assert property (
    @(posedge clk) disable iff (!rst_b)
    $fell(state_ff == ST_HALTED) |-> halted_ff == '0)
    else $error("outputs did not restart together");
  AST_HIZ_RELEASE: assert property (
    @(posedge clk) disable iff (!rst_b)
    $fell(stopReq_ff) |-> !clkOutPins[0].posOe_b)
    else $error("true leg not driven after release");
  AST_DEBOUNCE: assert property (
    @(posedge clk) disable iff (!rst_b)
    $rose(stopReq_ff) |-> $past(negRise) && !$past(outputHaltN)
      && !$past(haltSamp_ff))
    else $error("stop accepted without debounce");
  AST_MODE_RESET: assert property (
    @(posedge clk) disable iff (!rst_b)
    $rose(rst_b) |-> !hizMode)
    else $error("drive mode reset wrong");

  COV_STOP: cover property (@(posedge clk) $rose(state_ff == ST_HALTED));
  COV_RESTART: cover property (@(posedge clk) $fell(state_ff == ST_HALTED));
  COV_HIZ: cover property (@(posedge clk) halted_ff[0] && hizPark);

endmodule

// *** include/dcos_pkg.sv ***
// Constants and types for the differential clock output stop control
package dcos_pkg;

  // Width of each configuration byte, shared by all four outputs
  localparam int CFG_W = 8;

  // Stop drive mode bit and its values
  localparam int STOP_MODE_BIT = 6;
  localparam logic STOP_MODE_DRIVEN = 1'h0;
  localparam logic STOP_MODE_HIZ    = 1'h1;

  // Stoppable bit positions for the four outputs
  localparam int NUM_OUT = 4;
  localparam int STOPPABLE_POS [NUM_OUT] = '{1, 2, 5, 6};

  // Reset values of the configuration bytes
  localparam logic [7:0] MODE_RESET  = 8'h07;
  localparam logic [7:0] STOPEN_RESET = 8'h00;

  // Register offsets
  localparam logic [1:0] ADDR_MODE   = 2'h0;
  localparam logic [1:0] ADDR_STOPEN = 2'h2;
  localparam logic [1:0] ADDR_STATUS = 2'h3;

  // Debounce depth in complement-clock rising edges
  localparam int DEBOUNCE_EDGES = 2;

  // Restart latency window in output clock periods
  localparam int RESTART_MIN = 2;
  localparam int RESTART_MAX = 6;

  // Tri-state release drive-up limit
  localparam int    DRIVE_UP_NS  = 10;
  localparam int    CLK_PERIOD_NS = 40;
  localparam int    DRIVE_UP_CYC =
    (DRIVE_UP_NS / CLK_PERIOD_NS) < 1 ? 1 : DRIVE_UP_NS / CLK_PERIOD_NS;

  // One output's pin drive: value and active-low enable per leg
  typedef struct packed {
    logic posVal;
    logic posOe_b;
    logic negVal;
    logic negOe_b;
  } dcos_pins_t;

  typedef enum logic [1:0] {
    ST_RUN,
    ST_HALTING,
    ST_HALTED
  } dcos_state_t;

endpackage

// *** dv/dcos_ref_src.sv ***
// Reference clock source model feeding the stop control
module dcos_ref_src #(
  parameter int HALF_NS  = 160,
  parameter int START_NS = 17
) (
  // Reference clock level
  output logic refClockIn
);
  timeunit 1ns;
  timeprecision 1ps;

  // Free-running and always valid, never stopped while stop is in use
  initial begin
    refClockIn = 1'b0;
    #(START_NS);
    forever begin
      #(HALF_NS) refClockIn = ~refClockIn;
    end
  end
endmodule

// *** dv/dcos_ctrl_tb_top.sv ***
// Self-checking testbench for the output stop control
module dcos_ctrl_tb_top
  import dcos_pkg::*;
;
  timeunit 1ns;
  timeprecision 1ps;

  logic             clk;
  logic             rst_b;
  logic             refClockIn;
  logic             outputHaltN;
  logic [1:0]       regAddr;
  logic [7:0]       regWdata;
  logic             regWr;
  logic             regRd;
  logic [7:0]       regRdata;
  logic [7:0]       v;
  logic [7:0]       parkMask;
  logic [7:0]       parkVal;
  dcos_pins_t [3:0] clkOutPins;
  int               num_errors;
  int               cmp_count;

  // Reference half period, and full period in clk cycles
  localparam int REF_HALF_NS = 160;
  localparam int REF_CYC     = 2 * REF_HALF_NS / CLK_PERIOD_NS;

  dcos_ref_src #(.HALF_NS(REF_HALF_NS)) dcos_ref_src_i (
    .refClockIn(refClockIn)
  );

  dcos_ctrl dcos_ctrl_i (
    .clk(clk), .rst_b(rst_b), .refClockIn(refClockIn),
    .outputHaltN(outputHaltN), .regAddr(regAddr), .regWdata(regWdata),
    .regWr(regWr), .regRd(regRd), .regRdata(regRdata),
    .clkOutPins(clkOutPins)
  );

  always #20 clk = ~clk;

  //////////////////////////////////////////////////////////////////////////
  task automatic chk(input logic [7:0] seen, input logic [7:0] exp);
    cmp_count++;
    if (seen !== exp) begin
      num_errors++;
      $display("Error %0t: saw %h, expected %h", $time, seen, exp);
    end
  endtask

  task automatic wr(input logic [1:0] a, input logic [7:0] d);
    @(posedge clk);
    regAddr  <= a;
    regWdata <= d;
    regWr    <= 1'b1;
    @(posedge clk);
    regWr    <= 1'b0;
  endtask

  // Data stands only in the cycle after the strobe
  task automatic rd(input logic [1:0] a, output logic [7:0] d);
    @(posedge clk);
    regAddr <= a;
    regRd   <= 1'b1;
    @(posedge clk);
    regRd   <= 1'b0;
    @(negedge clk);
    d = regRdata;
  endtask

  function automatic logic [7:0] pk(input dcos_pins_t p);
    return {4'h0, p};
  endfunction

  function automatic logic [7:0] runPins();
    return {4'h0, refClockIn, 1'b0, ~refClockIn, 1'b0};
  endfunction

  task automatic complete_run();
    $display("Comparisons %0d, mismatches %0d", cmp_count, num_errors);
    if (num_errors == 0 && cmp_count > 0) begin
      $display("verification passed");
    end else begin
      $display("verification failed");
    end
    $finish;
  endtask

  //////////////////////////////////////////////////////////////////////////
  initial begin
    #(3000 * 40);
    num_errors++;
    complete_run();
  end

  initial begin
    clk = 1'b0;
    rst_b = 1'b0;
    outputHaltN = 1'b1;
    regAddr = 2'h0;
    regWdata = 8'h00;
    regWr = 1'b0;
    regRd = 1'b0;
    num_errors = 0;
    cmp_count = 0;
    repeat (3) @(posedge clk);
    rst_b <= 1'b1;
    rd(ADDR_MODE, v);
    chk(v, MODE_RESET);
    rd(ADDR_STOPEN, v);
    chk(v, STOPEN_RESET);
    wr(2'h1, 8'hFF);
    rd(2'h1, v);
    chk(v, 8'h00);
    // Outputs 0 and 2 stoppable, 1 and 3 free-running
    wr(ADDR_STOPEN, 8'h22);
    rd(ADDR_STOPEN, v);
    chk(v, 8'h22);
    // Low pulse seen by only one complement edge must be ignored
    @(negedge refClockIn);
    @(posedge clk);
    outputHaltN <= 1'h0;
    repeat (REF_CYC) @(posedge clk);
    outputHaltN <= 1'h1;
    repeat (20) @(posedge clk);
    rd(ADDR_STATUS, v);
    chk(v & 8'h3F, 8'h00);
    for (int m = 0; m < 2; m++) begin
      wr(ADDR_MODE, (m == 1) ? 8'h47 : 8'h07);
      outputHaltN <= 1'h0;
      // Values of undriven legs are not compared, their enables are
      parkMask = (m == 1) ? 8'h05 : 8'h0D;
      parkVal  = (m == 1) ? 8'h05 : 8'h09;
      repeat (40) @(posedge clk);
      @(negedge clk);
      chk(pk(clkOutPins[0]) & parkMask, parkVal);
      chk(pk(clkOutPins[2]) & parkMask, parkVal);
      chk(pk(clkOutPins[1]), runPins());
      chk(pk(clkOutPins[3]), runPins());
      rd(ADDR_STATUS, v);
      chk(v & 8'h3F, 8'h35);
      // Release just after a complement edge so the debounce phase is known
      @(negedge refClockIn);
      @(posedge clk);
      outputHaltN <= 1'h1;
      repeat (RESTART_MIN * REF_CYC - 1) @(posedge clk);
      @(negedge clk);
      chk(pk(clkOutPins[0]) & parkMask, parkVal);
      @(posedge clk);
      @(negedge clk);
      chk(pk(clkOutPins[0]), 8'h09);
      chk(pk(clkOutPins[2]), 8'h09);
      repeat ((RESTART_MAX - RESTART_MIN) * REF_CYC) @(posedge clk);
      @(negedge clk);
      chk(pk(clkOutPins[0]), runPins());
      chk(pk(clkOutPins[2]), runPins());
      rd(ADDR_STATUS, v);
      chk(v & 8'h3F, 8'h00);
    end
    complete_run();
  end
endmodule
